//--- src/sqr_pkg.sv
package sqr_pkg;
   // avalon word offsets
   localparam logic [2:0] CTRL_OFS   = 3'h0;
   localparam logic [2:0] SRC_OFS    = 3'h1;
   localparam logic [2:0] PC_OFS     = 3'h2;
   localparam logic [2:0] WP_OFS     = 3'h3;
   localparam logic [2:0] STATUS_OFS = 3'h4;
   localparam logic [2:0] DATA_OFS   = 3'h5;
   // control word fields
   localparam int CTRL_INSTR_LSB = 0;
   localparam int CTRL_COUNT_LSB = 4;
   localparam int CTRL_REG_LSB   = 8;
   localparam int CTRL_START_BIT = 31;
   // bus status codes
   localparam logic [3:0] CODE_SRC   = 4'h1;
   localparam logic [3:0] CODE_IMM   = 4'h2;
   localparam logic [3:0] CODE_FETCH = 4'h3;
   localparam logic [3:0] CODE_REG   = 4'h6;
   localparam logic [3:0] CODE_ALU   = 4'h9;
   localparam logic [3:0] CODE_IO    = 4'hb;
   localparam logic [3:0] CODE_PTR   = 4'hc;
   localparam logic [3:0] CODE_FLAGS = 4'hd;
   // step cycle counts and the bit base register number
   localparam logic [5:0] SERIAL_BIT_OUTPUT_INSTR_ALU_CYCLES = 6'h04;
   localparam logic [5:0] FLAG_ALU_CYCLES = 6'h02;
   localparam logic [5:0] MASK_ALU_CYCLES = 6'h02;
   localparam logic [5:0] LST_ALU_CYCLES  = 6'h03;
   localparam logic [5:0] MPY_ALU_CYCLES  = 6'h12;
   localparam logic [5:0] ONE_CYCLE       = 6'h01;
   localparam logic [5:0] FULL_BIT_LEN    = 6'h20;
   localparam logic [3:0] BIT_BASE_REG    = 4'hc;
   // reset values
   localparam logic [15:0] PC_RESET  = 16'h0000;
   localparam logic [15:0] WP_RESET  = 16'h0000;
   localparam logic [3:0]  MASK_RESET = 4'h0;

   typedef enum logic [3:0] {
      INSTR_SERIAL_OUT = 4'h0,
      INSTR_LD_DEST    = 4'h1,
      INSTR_LD_SRC     = 4'h2,
      INSTR_LOAD_IMM   = 4'h3,
      INSTR_LOAD_MASK  = 4'h4,
      INSTR_LOAD_FLAGS = 4'h5,
      INSTR_PTR_REG    = 4'h6,
      INSTR_PTR_IMM    = 4'h7,
      INSTR_MULTIPLY   = 4'h8
   } sqr_instr_e;

   typedef enum logic [3:0] {
      S_IDLE, S_REG_RD, S_IMM, S_ALU, S_IO, S_FLAGS, S_FETCH,
      S_REG_WR, S_PTR, S_WR_MSW, S_WR_LSW, S_ALU_END
   } sqr_step_e;
endpackage

//--- src/sqr_sequencer.sv
// Decided for this implementation: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ps
module sqr_sequencer (
   input  wire logic        clk_in,
   input  wire logic        reset_in,
   input  wire logic        ce_in,
   input  wire logic [2:0]  avs_address_in,
   input  wire logic        avs_read_in,
   input  wire logic        avs_write_in,
   input  wire logic [31:0] avs_writedata_in,
   output logic      [31:0] avs_readdata_out,
   output logic             avs_waitrequest_out,
   input  wire logic [15:0] bus_rdata_in,
   input  wire logic        int_req_in,
   input  wire logic [3:0]  int_level_in,
   output logic      [3:0]  bus_status_out,
   output logic             bus_active_out,
   output logic             bus_xfer_out,
   output logic             bus_we_out,
   output logic      [15:0] bus_addr_out,
   output logic      [15:0] bus_wdata_out,
   output logic             ldd_flag_out,
   output logic             lds_flag_out,
   output logic      [3:0]  int_mask_out,
   output logic             int_accept_out
);
   sqr_pkg::sqr_step_e  step, next_step;
   sqr_pkg::sqr_instr_e instr_q, next_instr;
   logic [3:0]  cnt_q, next_cnt, reg_q, next_reg, io_bit, next_io_bit;
   logic [15:0] pc, next_pc, wp, next_wp, src_q, next_src, data_q, next_data;
   logic [15:0] base_q, next_base, flags_q, next_flags, opcode_q, next_opcode;
   logic [31:0] prod, next_prod;
   logic [3:0]  next_status, next_mask;
   logic        next_active, next_xfer, next_we, next_ldd, next_lds, next_accept;
   logic [15:0] next_addr, next_wdata;
   logic [5:0]  rem, load_val, io_len;
   logic        advance, load, start_take, wr_take, rd_take, busy;
   logic        next_wait;
   logic [31:0] next_rdata;

   sqr_step_counter #(.W(6)) u_len (
      .clk_in    (clk_in),
      .reset_in  (reset_in),
      .ce_in     (ce_in),
      .load_in   (load),
      .value_in  (load_val),
      .count_out (rem)
   );

   function automatic logic valid_instr(input logic [3:0] code);
      return code <= 4'h8;
   endfunction

   function automatic sqr_pkg::sqr_step_e first_of(input sqr_pkg::sqr_instr_e i);
      unique case (i)
         sqr_pkg::INSTR_LD_DEST, sqr_pkg::INSTR_LD_SRC:                          return sqr_pkg::S_ALU;
         sqr_pkg::INSTR_LOAD_IMM, sqr_pkg::INSTR_LOAD_MASK, sqr_pkg::INSTR_PTR_IMM: return sqr_pkg::S_IMM;
         default:                                                                  return sqr_pkg::S_REG_RD;
      endcase
   endfunction

   function automatic sqr_pkg::sqr_step_e follow(input sqr_pkg::sqr_step_e s, input sqr_pkg::sqr_instr_e i);
      sqr_pkg::sqr_step_e n;
      n = sqr_pkg::S_IDLE;
      unique case (s)
         sqr_pkg::S_REG_RD: n = (i == sqr_pkg::INSTR_PTR_REG) ? sqr_pkg::S_FETCH : sqr_pkg::S_ALU;
         sqr_pkg::S_IMM:    n = (i == sqr_pkg::INSTR_LOAD_MASK) ? sqr_pkg::S_ALU : sqr_pkg::S_FETCH;
         sqr_pkg::S_ALU: begin
            unique case (i)
               sqr_pkg::INSTR_SERIAL_OUT: n = sqr_pkg::S_IO;
               sqr_pkg::INSTR_LOAD_FLAGS: n = sqr_pkg::S_FLAGS;
               sqr_pkg::INSTR_MULTIPLY:   n = sqr_pkg::S_WR_MSW;
               sqr_pkg::INSTR_LOAD_MASK:  n = sqr_pkg::S_FETCH;
               default:                   n = sqr_pkg::S_IDLE;
            endcase
         end
         sqr_pkg::S_IO, sqr_pkg::S_FLAGS, sqr_pkg::S_WR_MSW: n = sqr_pkg::S_FETCH;
         sqr_pkg::S_FETCH: begin
            unique case (i)
               sqr_pkg::INSTR_LOAD_IMM:                         n = sqr_pkg::S_REG_WR;
               sqr_pkg::INSTR_PTR_REG, sqr_pkg::INSTR_PTR_IMM:  n = sqr_pkg::S_PTR;
               sqr_pkg::INSTR_MULTIPLY:                         n = sqr_pkg::S_WR_LSW;
               default:                                         n = sqr_pkg::S_ALU_END;
            endcase
         end
         sqr_pkg::S_IDLE, sqr_pkg::S_REG_WR, sqr_pkg::S_PTR, sqr_pkg::S_WR_LSW, sqr_pkg::S_ALU_END: n = sqr_pkg::S_IDLE;
      endcase
      return n;
   endfunction

   // avalon slave: every access sees exactly one wait cycle
   always_comb begin
      rd_take   = avs_read_in && !avs_waitrequest_out;
      wr_take   = avs_write_in && !avs_waitrequest_out;
      next_wait = !((avs_read_in || avs_write_in) && avs_waitrequest_out);
      busy      = (step != sqr_pkg::S_IDLE);
      unique case (avs_address_in)
         sqr_pkg::CTRL_OFS:   next_rdata = {16'h0000, reg_q, cnt_q, 3'h0, busy, 4'(instr_q)};
         sqr_pkg::SRC_OFS:    next_rdata = {16'h0000, src_q};
         sqr_pkg::PC_OFS:     next_rdata = {16'h0000, pc};
         sqr_pkg::WP_OFS:     next_rdata = {16'h0000, wp};
         sqr_pkg::STATUS_OFS: next_rdata = {flags_q, 8'h00, int_mask_out, lds_flag_out, ldd_flag_out, 1'b0, busy};
         sqr_pkg::DATA_OFS:   next_rdata = {opcode_q, data_q};
         default:             next_rdata = 32'h0000_0000;
      endcase
      if (rd_take) begin
         next_rdata = avs_readdata_out;
      end
   end

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         avs_waitrequest_out <= 1'b1;
         avs_readdata_out    <= 32'h0000_0000;
      end else if (ce_in) begin
         avs_waitrequest_out <= next_wait;
         avs_readdata_out    <= next_rdata;
      end
   end

   // sequencer and datapath
   always_comb begin
      start_take = wr_take && !busy && (avs_address_in == sqr_pkg::CTRL_OFS)
                   && avs_writedata_in[sqr_pkg::CTRL_START_BIT]
                   && valid_instr(avs_writedata_in[sqr_pkg::CTRL_INSTR_LSB +: 4]);
      next_instr = instr_q;
      next_cnt   = cnt_q;
      next_reg   = reg_q;
      next_src   = src_q;
      next_pc    = pc;
      next_wp    = wp;
      next_data  = data_q;
      next_base  = base_q;
      next_flags = flags_q;
      next_opcode = opcode_q;
      next_prod  = prod;
      next_mask  = int_mask_out;
      next_ldd   = ldd_flag_out;
      next_lds   = lds_flag_out;
      next_io_bit = io_bit;
      advance    = busy && (rem == 6'h00);
      next_step  = step;
      // software writes to the datapath are dropped while a sequence runs
      if (wr_take && !busy) begin
         unique case (avs_address_in)
            sqr_pkg::SRC_OFS: next_src = avs_writedata_in[15:0];
            sqr_pkg::PC_OFS:  next_pc  = avs_writedata_in[15:0];
            sqr_pkg::WP_OFS:  next_wp  = avs_writedata_in[15:0];
            default: ;
         endcase
      end
      if (start_take) begin
         next_instr = sqr_pkg::sqr_instr_e'(avs_writedata_in[sqr_pkg::CTRL_INSTR_LSB +: 4]);
         next_cnt   = avs_writedata_in[sqr_pkg::CTRL_COUNT_LSB +: 4];
         next_reg   = avs_writedata_in[sqr_pkg::CTRL_REG_LSB +: 4];
         next_step  = first_of(next_instr);
      end else if (advance) begin
         next_step = follow(step, instr_q);
         unique case (step)
            sqr_pkg::S_REG_RD: begin
               next_data = bus_rdata_in;
               if (instr_q == sqr_pkg::INSTR_SERIAL_OUT) begin
                  next_base = bus_rdata_in;
               end
               next_prod = 32'(src_q) * 32'(bus_rdata_in);
            end
            sqr_pkg::S_IMM: begin
               next_data = bus_rdata_in;
               next_pc   = pc + 16'h0002;
            end
            sqr_pkg::S_FETCH: begin
               next_opcode = bus_rdata_in;
               next_pc     = pc + 16'h0002;
            end
            sqr_pkg::S_ALU: begin
               if (instr_q == sqr_pkg::INSTR_LD_DEST) begin
                  next_ldd = 1'b1;
               end
               if (instr_q == sqr_pkg::INSTR_LD_SRC) begin
                  next_lds = 1'b1;
               end
            end
            sqr_pkg::S_FLAGS: next_flags = data_q;
            sqr_pkg::S_PTR:   next_wp = data_q;
            sqr_pkg::S_ALU_END: begin
               if (instr_q == sqr_pkg::INSTR_LOAD_MASK) begin
                  next_mask = data_q[3:0];
               end
            end
            default: ;
         endcase
      end
      // bit index steps after every second i/o state
      if (next_step == sqr_pkg::S_IO && step != sqr_pkg::S_IO) begin
         next_io_bit = 4'h0;
      end else if (step == sqr_pkg::S_IO && !rem[0] && rem != 6'h00) begin
         next_io_bit = io_bit + 4'h1;
      end
      io_len = (next_cnt == 4'h0) ? sqr_pkg::FULL_BIT_LEN : {1'b0, next_cnt, 1'b0};
      unique case (next_step)
         sqr_pkg::S_ALU: begin
            unique case (next_instr)
               sqr_pkg::INSTR_SERIAL_OUT: load_val = sqr_pkg::SERIAL_BIT_OUTPUT_INSTR_ALU_CYCLES - 6'h01;
               sqr_pkg::INSTR_LOAD_MASK:  load_val = sqr_pkg::MASK_ALU_CYCLES - 6'h01;
               sqr_pkg::INSTR_LOAD_FLAGS: load_val = sqr_pkg::LST_ALU_CYCLES - 6'h01;
               sqr_pkg::INSTR_MULTIPLY:   load_val = sqr_pkg::MPY_ALU_CYCLES - 6'h01;
               default:                   load_val = sqr_pkg::FLAG_ALU_CYCLES - 6'h01;
            endcase
         end
         sqr_pkg::S_IO: load_val = io_len - 6'h01;
         default:       load_val = sqr_pkg::ONE_CYCLE - 6'h01;
      endcase
      load = start_take || advance;
      // bus outputs are registered from the next step so they line up with it
      next_active = (next_step != sqr_pkg::S_IDLE);
      next_status = sqr_pkg::CODE_ALU;
      next_xfer   = 1'b0;
      next_we     = 1'b0;
      next_addr   = 16'h0000;
      next_wdata  = 16'h0000;
      unique case (next_step)
         sqr_pkg::S_REG_RD: begin
            next_status = sqr_pkg::CODE_REG;
            next_xfer   = 1'b1;
            next_addr   = (next_instr == sqr_pkg::INSTR_SERIAL_OUT)
                          ? next_wp + {11'h000, sqr_pkg::BIT_BASE_REG, 1'b0}
                          : next_wp + {11'h000, next_reg, 1'b0};
         end
         sqr_pkg::S_IMM, sqr_pkg::S_FETCH: begin
            next_status = (next_step == sqr_pkg::S_IMM) ? sqr_pkg::CODE_IMM : sqr_pkg::CODE_FETCH;
            next_xfer   = 1'b1;
            next_addr   = next_pc;
         end
         sqr_pkg::S_IO: begin
            next_status = sqr_pkg::CODE_IO;
            next_xfer   = 1'b1;
            next_we     = 1'b1;
            next_addr   = base_q + {11'h000, next_io_bit, 1'b0};
            next_wdata  = {15'h0000, src_q[next_io_bit]};
         end
         sqr_pkg::S_FLAGS: begin
            next_status = sqr_pkg::CODE_FLAGS;
            next_addr   = data_q;
         end
         sqr_pkg::S_PTR: begin
            next_status = sqr_pkg::CODE_PTR;
            next_addr   = data_q;
         end
         sqr_pkg::S_REG_WR, sqr_pkg::S_WR_MSW, sqr_pkg::S_WR_LSW: begin
            next_status = sqr_pkg::CODE_REG;
            next_xfer   = 1'b1;
            next_we     = 1'b1;
            next_addr   = wp + {11'h000, reg_q, 1'b0};
            next_wdata  = data_q;
            if (next_step == sqr_pkg::S_WR_MSW) begin
               next_wdata = next_prod[31:16];
            end
            if (next_step == sqr_pkg::S_WR_LSW) begin
               next_addr  = wp + {11'h000, reg_q, 1'b0} + 16'h0002;
               next_wdata = prod[15:0];
            end
         end
         sqr_pkg::S_IDLE, sqr_pkg::S_ALU, sqr_pkg::S_ALU_END: begin
            next_status = sqr_pkg::CODE_ALU;
         end
      endcase
      // a level above the mask number is held off
      next_accept = int_req_in && (int_level_in <= next_mask);
   end

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         step           <= sqr_pkg::S_IDLE;
         instr_q        <= sqr_pkg::INSTR_SERIAL_OUT;
         cnt_q          <= 4'h0;
         reg_q          <= 4'h0;
         io_bit         <= 4'h0;
         src_q          <= 16'h0000;
         pc             <= sqr_pkg::PC_RESET;
         wp             <= sqr_pkg::WP_RESET;
         data_q         <= 16'h0000;
         base_q         <= 16'h0000;
         flags_q        <= 16'h0000;
         opcode_q       <= 16'h0000;
         prod           <= 32'h0000_0000;
         int_mask_out   <= sqr_pkg::MASK_RESET;
         ldd_flag_out   <= 1'b0;
         lds_flag_out   <= 1'b0;
         int_accept_out <= 1'b0;
         bus_status_out <= sqr_pkg::CODE_ALU;
         bus_active_out <= 1'b0;
         bus_xfer_out   <= 1'b0;
         bus_we_out     <= 1'b0;
         bus_addr_out   <= 16'h0000;
         bus_wdata_out  <= 16'h0000;
      end else if (ce_in) begin
         step           <= next_step;
         instr_q        <= next_instr;
         cnt_q          <= next_cnt;
         reg_q          <= next_reg;
         io_bit         <= next_io_bit;
         src_q          <= next_src;
         pc             <= next_pc;
         wp             <= next_wp;
         data_q         <= next_data;
         base_q         <= next_base;
         flags_q        <= next_flags;
         opcode_q       <= next_opcode;
         prod           <= next_prod;
         int_mask_out   <= next_mask;
         ldd_flag_out   <= next_ldd;
         lds_flag_out   <= next_lds;
         int_accept_out <= next_accept;
         bus_status_out <= next_status;
         bus_active_out <= next_active;
         bus_xfer_out   <= next_xfer;
         bus_we_out     <= next_we;
         bus_addr_out   <= next_addr;
         bus_wdata_out  <= next_wdata;
      end
   end

   // helper counters read only by the checks below
   logic [4:0] alu_run;
   logic [5:0] io_states;
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         alu_run   <= 5'h00;
         io_states <= 6'h00;
      end else if (ce_in) begin
         alu_run   <= (bus_active_out && bus_status_out == sqr_pkg::CODE_ALU) ? alu_run + 5'h01 : 5'h00;
         io_states <= (step == sqr_pkg::S_IO) ? io_states + 6'h01 : 6'h00;
      end
   end

   default clocking cb @(posedge clk_in iff ce_in); endclocking
   default disable iff (reset_in);

   sequence s_fetch_then_alu;
      bus_status_out == sqr_pkg::CODE_FETCH && bus_xfer_out ##1 bus_status_out == sqr_pkg::CODE_ALU;
   endsequence

   property p_serial_bit_output_instr_base;
      start_take && next_instr == sqr_pkg::INSTR_SERIAL_OUT |=> bus_status_out == sqr_pkg::CODE_REG
         && bus_addr_out == wp + 16'h0018 && !bus_we_out;
   endproperty
   a_serial_bit_output_instr_base: assert property (p_serial_bit_output_instr_base) else $error("bit base read missing");

   property p_serial_bit_output_instr_alu;
      start_take && next_instr == sqr_pkg::INSTR_SERIAL_OUT |=> ##1 (bus_status_out == sqr_pkg::CODE_ALU)[*4]
         ##1 bus_status_out == sqr_pkg::CODE_IO;
   endproperty
   a_serial_bit_output_instr_alu: assert property (p_serial_bit_output_instr_alu) else $error("four internal cycles not seen");

   property p_serial_bit_output_instr_io;
      step == sqr_pkg::S_IO && rem == 6'h00 |-> (io_states + 6'h01 == ((cnt_q == 4'h0) ? 6'h20 : {1'b0, cnt_q, 1'b0}))
         ##1 s_fetch_then_alu;
   endproperty
   a_serial_bit_output_instr_io: assert property (p_serial_bit_output_instr_io) else $error("i/o write length wrong");

   property p_ldd;
      start_take && next_instr == sqr_pkg::INSTR_LD_DEST |=> (bus_status_out == sqr_pkg::CODE_ALU)[*2]
         ##1 ldd_flag_out && !bus_active_out;
   endproperty
   a_ldd: assert property (p_ldd) else $error("dest flag not updated");

   property p_li;
      start_take && next_instr == sqr_pkg::INSTR_LOAD_IMM |=> bus_status_out == sqr_pkg::CODE_IMM
         ##1 bus_status_out == sqr_pkg::CODE_FETCH
         ##1 bus_status_out == sqr_pkg::CODE_REG && bus_we_out && bus_wdata_out == data_q;
   endproperty
   a_li: assert property (p_li) else $error("load immediate order wrong");

   property p_load_interrupt_mask_instr;
      start_take && next_instr == sqr_pkg::INSTR_LOAD_MASK |=> bus_status_out == sqr_pkg::CODE_IMM
         ##1 (bus_status_out == sqr_pkg::CODE_ALU)[*2] ##1 s_fetch_then_alu;
   endproperty
   a_load_interrupt_mask_instr: assert property (p_load_interrupt_mask_instr) else $error("load mask order wrong");

   property p_mask;
      step == sqr_pkg::S_ALU_END && instr_q == sqr_pkg::INSTR_LOAD_MASK |=> int_mask_out == 4'($past(data_q))
         ##1 int_accept_out == ($past(int_req_in) && ($past(int_level_in) <= $past(int_mask_out)));
   endproperty
   a_mask: assert property (p_mask) else $error("new mask not applied");

   property p_lst;
      start_take && next_instr == sqr_pkg::INSTR_LOAD_FLAGS |=> bus_status_out == sqr_pkg::CODE_REG
         ##1 (bus_status_out == sqr_pkg::CODE_ALU)[*3]
         ##1 bus_status_out == sqr_pkg::CODE_FLAGS && bus_addr_out == data_q ##1 s_fetch_then_alu;
   endproperty
   a_lst: assert property (p_lst) else $error("load flags order wrong");

   property p_lwp;
      start_take && (next_instr == sqr_pkg::INSTR_PTR_REG || next_instr == sqr_pkg::INSTR_PTR_IMM)
         |=> (bus_status_out == sqr_pkg::CODE_REG || bus_status_out == sqr_pkg::CODE_IMM)
         ##1 bus_status_out == sqr_pkg::CODE_FETCH ##1 bus_status_out == sqr_pkg::CODE_PTR
         ##1 wp == $past(bus_addr_out);
   endproperty
   a_lwp: assert property (p_lwp) else $error("pointer load wrong");

   property p_mpy_alu;
      step == sqr_pkg::S_WR_MSW && $past(step) != sqr_pkg::S_WR_MSW |-> alu_run == 5'h12;
   endproperty
   a_mpy_alu: assert property (p_mpy_alu) else $error("multiply internal run not eighteen");

   property p_mpy_wr;
      step == sqr_pkg::S_WR_MSW |-> bus_we_out && bus_wdata_out == prod[31:16]
         ##1 bus_status_out == sqr_pkg::CODE_FETCH
         ##1 bus_we_out && bus_wdata_out == prod[15:0] && bus_addr_out == $past(bus_addr_out, 2) + 16'h0002;
   endproperty
   a_mpy_wr: assert property (p_mpy_wr) else $error("multiply result writes wrong");

   property p_alu_quiet;
      bus_status_out == sqr_pkg::CODE_ALU |-> !bus_xfer_out && !bus_we_out;
   endproperty
   a_alu_quiet: assert property (p_alu_quiet) else $error("transfer during internal cycle");
endmodule

//--- src/sqr_step_counter.sv
`timescale 1ns/1ps
module sqr_step_counter #(
   parameter int W = 6
) (
   input  wire logic         clk_in,
   input  wire logic         reset_in,
   input  wire logic         ce_in,
   input  wire logic         load_in,
   input  wire logic [W-1:0] value_in,
   output logic      [W-1:0] count_out
);
   logic [W-1:0] next_count;

   always_comb begin
      next_count = count_out;
      if (load_in) begin
         next_count = value_in;
      end else if (count_out != '0) begin
         next_count = count_out - W'(1);
      end
   end

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         count_out <= '0;
      end else if (ce_in) begin
         count_out <= next_count;
      end
   end
endmodule

//--- test/sqr_mem_model.sv
`timescale 1ns/1ps
module sqr_mem_model (
   input  wire logic        clk_in,
   input  wire logic        bus_xfer_in,
   input  wire logic        bus_we_in,
   input  wire logic [15:0] bus_addr_in,
   output logic      [15:0] bus_rdata_out
);
   logic [15:0] last;
   // undriven cycles show the inverse, so stale data never matches
   assign bus_rdata_out = (bus_xfer_in && !bus_we_in) ? (bus_addr_in ^ 16'ha5c3) : ~last;
   always_ff @(posedge clk_in) begin
      last <= bus_rdata_out;
   end
endmodule

//--- test/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   logic        clk_in = 0, reset_in = 1, avs_read_in = 0, avs_write_in = 0, int_req_in = 0;
   logic [2:0]  avs_address_in = 0;
   logic [31:0] avs_writedata_in = 0, avs_readdata_out, rd, wq;
   logic        avs_waitrequest_out, bus_active_out, bus_xfer_out, bus_we_out;
   logic        ldd_flag_out, lds_flag_out, int_accept_out;
   logic [3:0]  int_level_in = 0, bus_status_out, int_mask_out;
   logic [15:0] bus_rdata_in, bus_addr_out, bus_wdata_out;
   logic [63:0] sig;
   int          bad_count = 0, n_checks = 0, cyc = 0, n;
   always #2 clk_in = ~clk_in;
   sqr_sequencer dut_u (.clk_in, .reset_in, .ce_in(1'b1), .avs_address_in, .avs_read_in, .avs_write_in,
      .avs_writedata_in, .avs_readdata_out, .avs_waitrequest_out, .bus_rdata_in, .int_req_in, .int_level_in,
      .bus_status_out, .bus_active_out, .bus_xfer_out, .bus_we_out, .bus_addr_out, .bus_wdata_out,
      .ldd_flag_out, .lds_flag_out, .int_mask_out, .int_accept_out);
   sqr_mem_model mem_u (.clk_in, .bus_xfer_in(bus_xfer_out), .bus_we_in(bus_we_out),
      .bus_addr_in(bus_addr_out), .bus_rdata_out(bus_rdata_in));
   task chk(input logic [63:0] s, input logic [63:0] e);
      n_checks++;
      if (s !== e) begin
         bad_count++;
         $display("MISMATCH %0t seen %h expected %h", $time, s, e);
      end
   endtask
   task stop_test;
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // one edge with the request low first, so no signal is assigned twice in a step
   task av(input logic w, input logic [2:0] a, input logic [31:0] d);
      @(posedge clk_in);
      avs_address_in <= a;
      avs_writedata_in <= d;
      avs_write_in <= w;
      avs_read_in <= !w;
      // no local limit: only the bench timeout may end a wait
      do begin
         @(posedge clk_in);
      end while (avs_waitrequest_out !== 1'b0);
      rd = avs_readdata_out;
      avs_write_in <= 0;
      avs_read_in <= 0;
   endtask
   // records the code of each bus state as one hex digit, keeping the last 16
   task run(input logic [15:0] c, input logic [63:0] es, input int en);
      int x9;
      sig = 0;
      n = 0;
      x9 = 0;
      av(1, 3'h0, {16'h8000, c});
      repeat (60) begin
         @(posedge clk_in);
         if (bus_active_out !== 1'b1) break;
         sig = {sig[59:0], bus_status_out};
         if (bus_we_out === 1'b1) wq = {wq[15:0], bus_wdata_out};
         if (bus_status_out == 4'h9 && bus_xfer_out !== 1'b0) x9++;
         n++;
      end
      chk(sig, es);
      chk(n, en);
      chk(x9, 0);
      $display("test %h done", c);
   endtask
   always @(posedge clk_in) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         bad_count++;
         stop_test;
      end
   end
   initial begin
      repeat (3) @(posedge clk_in);
      reset_in <= 0;
      av(1, 3'h2, 32'h100);
      av(1, 3'h3, 32'h200);
      av(1, 3'h1, 32'h1234);
      av(0, 3'h6, 0);
      chk(rd, 0);
      run(16'h0103, 64'h236, 3);
      chk(wq[15:0], 16'h0100 ^ 16'ha5c3);
      run(16'h0004, 64'h29939, 5);
      chk(int_mask_out, 4'h7);
      int_req_in <= 1;
      int_level_in <= 4'h7;
      repeat (2) @(posedge clk_in);
      chk(int_accept_out, 1);
      int_level_in <= 4'h8;
      repeat (2) @(posedge clk_in);
      chk(int_accept_out, 0);
      run(16'h0108, 64'h9999999999999636, 22);
      chk(wq, 32'h1234 * 32'ha7c1);
      run(16'h0030, 64'h69999bbbbbb39, 13);
      chk(wq, 32'h0001_0001);
      run(16'h0001, 64'h99, 2);
      chk(ldd_flag_out, 1);
      run(16'h0002, 64'h99, 2);
      chk(lds_flag_out, 1);
      run(16'h0105, 64'h6999d39, 7);
      av(0, 3'h4, 0);
      chk(rd[31:16], 16'h0202 ^ 16'ha5c3);
      chk(rd[3:2], 2'b11);
      run(16'h0106, 64'h63c, 3);
      av(0, 3'h3, 0);
      chk(rd[15:0], 16'h0202 ^ 16'ha5c3);
      run(16'h0007, 64'h23c, 3);
      stop_test;
   end
endmodule
